// file: dsl_map.svh
// Register offsets, field positions and reset values for the split commitment limiter
`ifndef DSL_MAP_SVH
`define DSL_MAP_SVH
`define DSL_OFF_CAPLIM    8'h00
`define DSL_OFF_OUTSTAND  8'h04
`define DSL_OFF_STATUS    8'h08
`define DSL_CAP_LSB       0
`define DSL_LIM_LSB       16
`define DSL_CAP_RESET     16'h0010
`define DSL_LIM_RESET     16'h0010
`define DSL_LIM_UNLIMITED 16'hFFFF
`endif

// file: dsl_pkg.sv
// Types shared by the split commitment limiter
`default_nettype none
package dsl_pkg;
  typedef logic [15:0] dsl_adq_t;
  typedef enum logic [1:0] {
    DSL_TRACKING,
    DSL_UNTRACKED,
    DSL_RESYNC
  } dsl_mode_t;
endpackage : dsl_pkg
`default_nettype wire

// file: dsl_count_reg.sv
// Outstanding-commitment counter register with saturating add and subtract
`default_nettype none
module dsl_count_reg #(
  parameter int WIDTH = 17
) (
  // Clock and reset
  input  wire logic             clock,
  input  wire logic             reset,
  // Control
  input  wire logic             clear,
  input  wire logic             addEn,
  input  wire logic [WIDTH-1:0] addVal,
  input  wire logic             subEn,
  input  wire logic [WIDTH-1:0] subVal,
  // State
  output logic      [WIDTH-1:0] count
);
  logic [WIDTH-1:0] count_q;
  logic [WIDTH-1:0] count_d;
  logic [WIDTH:0]   sum;

  always_comb begin
    sum = {1'b0, count_q};
    if (addEn) begin
      sum = sum + {1'b0, addVal};
    end
    if (subEn) begin
      // Saturate at zero: a stray completion must not wrap the count
      sum = (sum > {1'b0, subVal}) ? sum - {1'b0, subVal} : '0;
    end
    count_d = clear ? '0 : (sum[WIDTH] ? '1 : sum[WIDTH-1:0]);
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      count_q <= '0;
    end else begin
      count_q <= count_d;
    end
  end

  assign count = count_q;
endmodule : dsl_count_reg
`default_nettype wire

// file: dsl_limiter.sv
// Downstream split transaction commitment limiter top
//
// The address-and-strobe port and the address map were chosen for this implementation.
`include "dsl_map.svh"
`default_nettype none
module dsl_limiter (
  // Clock and reset
  input  wire logic             clock,
  input  wire logic             reset,
  // Register port
  input  wire logic [7:0]       regAddr,
  input  wire logic [31:0]      regWrData,
  input  wire logic             regWrite,
  input  wire logic             regRead,
  output logic      [31:0]      regRdData,
  // EEPROM initialization load
  input  wire logic             eepromLoad,
  input  wire dsl_pkg::dsl_adq_t eepromLimit,
  // Split request from primary side
  input  wire logic             reqValid,
  input  wire dsl_pkg::dsl_adq_t reqSize,
  output logic                  reqGrant,
  output logic                  reqHeld,
  // Returned completion from secondary side
  input  wire logic             cplValid,
  input  wire dsl_pkg::dsl_adq_t cplSize,
  // Status
  output logic                  trackExact
);
  import dsl_pkg::*;

  localparam int CW = 17;

  dsl_adq_t  limit_q;
  dsl_adq_t  limit_d;
  dsl_mode_t mode_q;
  dsl_mode_t mode_d;
  logic [31:0] rdData_q;
  logic [31:0] rdData_d;
  logic      grant_q;
  logic      grant_d;
  logic      held_q;
  logic      held_d;
  logic      exact_q;
  logic      exact_d;
  logic [CW-1:0] count;
  logic      unlimited;
  logic      fits;
  logic      forward;
  logic      tracking;
  logic      limWrite;

  assign limWrite  = regWrite && (regAddr == `DSL_OFF_CAPLIM);
  assign unlimited = (limit_q == `DSL_LIM_UNLIMITED);
  // A limit written this cycle is seen by the next request, not this one
  // Combined commitment of all downstream split types versus registered limit
  assign fits      = ({1'b0, count} + {1'b0, 1'b0, reqSize})
                     <= {2'b00, limit_q};
  assign forward   = reqValid && (unlimited || fits);
  assign tracking  = !unlimited;

  // Limit register and EEPROM load
  always_comb begin
    limit_d = limit_q;
    if (eepromLoad) begin
      limit_d = eepromLimit;
    end
    if (limWrite) begin
      limit_d = regWrData[`DSL_LIM_LSB +: 16];
    end
  end

  // Tracking mode follows the limit; resync ends when nothing is outstanding
  always_comb begin
    mode_d = mode_q;
    unique case (mode_q)
      DSL_TRACKING: begin
        if (unlimited) begin
          mode_d = DSL_UNTRACKED;
        end
      end
      DSL_UNTRACKED: begin
        if (!unlimited) begin
          mode_d = DSL_RESYNC;
        end
      end
      DSL_RESYNC: begin
        if (unlimited) begin
          mode_d = DSL_UNTRACKED;
        end else if (count == '0) begin
          mode_d = DSL_TRACKING;
        end
      end
    endcase
  end

  // Capacity is a constant, so writes to the low half are dropped
  // Request answer and register read data
  always_comb begin
    grant_d  = forward;
    held_d   = reqValid && !forward;
    exact_d  = (mode_d == DSL_TRACKING);
    rdData_d = '0;
    if (regRead) begin
      unique case (regAddr)
        `DSL_OFF_CAPLIM:   rdData_d = {limit_q, `DSL_CAP_RESET};
        `DSL_OFF_OUTSTAND: rdData_d = {15'h0000, count};
        `DSL_OFF_STATUS:   rdData_d = {30'h0000_0000, exact_q, unlimited};
        default:           rdData_d = '0;
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      limit_q  <= `DSL_LIM_RESET;
      mode_q   <= DSL_TRACKING;
      rdData_q <= '0;
      grant_q  <= 1'b0;
      held_q   <= 1'b0;
      exact_q  <= 1'b1;
    end else begin
      limit_q  <= limit_d;
      mode_q   <= mode_d;
      rdData_q <= rdData_d;
      grant_q  <= grant_d;
      held_q   <= held_d;
      exact_q  <= exact_d;
    end
  end

  // Counting stops while untracked; drain subtracts sizes it never saw, clamping at zero
  dsl_count_reg #(
    .WIDTH(CW)
  ) u_count (
    .clock (clock),
    .reset (reset),
    .clear (unlimited),
    .addEn (forward && tracking),
    .addVal({1'b0, reqSize}),
    .subEn (cplValid && tracking),
    .subVal({1'b0, cplSize}),
    .count (count)
  );

  assign regRdData  = rdData_q;
  assign reqGrant   = grant_q;
  assign reqHeld    = held_q;
  assign trackExact = exact_q;

  // Checks
  // Request answers
  grant_fits_a: assert property (@(posedge clock) disable iff (reset)
    reqValid && !unlimited && !fits |=> !reqGrant && reqHeld)
    else $error("request over limit was granted");
  unlim_grant_a: assert property (@(posedge clock) disable iff (reset)
    reqValid && unlimited |=> reqGrant)
    else $error("unlimited request not granted");
  fit_grant_a: assert property (@(posedge clock) disable iff (reset)
    reqValid && fits |=> reqGrant && !reqHeld)
    else $error("request within limit was held");
  idle_answer_a: assert property (@(posedge clock) disable iff (reset)
    !reqValid |=> !reqGrant && !reqHeld)
    else $error("answer without a request");
  // Register port
  cap_read_a: assert property (@(posedge clock) disable iff (reset)
    regRead && regAddr == `DSL_OFF_CAPLIM |=> regRdData[15:0] == 16'h0010)
    else $error("capacity field wrong");
  idle_read_a: assert property (@(posedge clock) disable iff (reset)
    !regRead |=> regRdData == '0)
    else $error("read data outside read cycle");
  lim_write_a: assert property (@(posedge clock) disable iff (reset)
    limWrite |=> limit_q == $past(regWrData[31:16]))
    else $error("limit write not taken");
  lim_keep_a: assert property (@(posedge clock) disable iff (reset)
    !limWrite && !eepromLoad |=> $stable(limit_q))
    else $error("limit changed without a write");
  eeprom_a: assert property (@(posedge clock) disable iff (reset)
    eepromLoad && !limWrite |=> limit_q == $past(eepromLimit))
    else $error("eeprom load lost");
  status_read_a: assert property (@(posedge clock) disable iff (reset)
    regRead && regAddr == `DSL_OFF_STATUS
    |=> regRdData[1:0] == {$past(exact_q), $past(unlimited)})
    else $error("status read wrong");
  // Tracking mode and counter
  no_track_a: assert property (@(posedge clock) disable iff (reset)
    unlimited |=> count == '0)
    else $error("count kept while untracked");
  untrack_mode_a: assert property (@(posedge clock) disable iff (reset)
    unlimited |=> mode_q == DSL_UNTRACKED)
    else $error("untracked mode not entered");
  resync_a: assert property (@(posedge clock) disable iff (reset)
    mode_q == DSL_UNTRACKED && !unlimited |=> mode_q == DSL_RESYNC)
    else $error("resync not entered");
  resync_exit_a: assert property (@(posedge clock) disable iff (reset)
    mode_q == DSL_RESYNC && !unlimited && count == '0 |=> mode_q == DSL_TRACKING)
    else $error("resync did not end");
  exact_flag_a: assert property (@(posedge clock) disable iff (reset)
    trackExact == (mode_q == DSL_TRACKING))
    else $error("exact flag disagrees with mode");
  count_add_a: assert property (@(posedge clock) disable iff (reset)
    forward && tracking && !cplValid && !$rose(unlimited)
    |=> unlimited || count == $past(count) + {1'b0, $past(reqSize)})
    else $error("counter did not add");
  // Completions for untracked requests clamp at zero
  count_sub_a: assert property (@(posedge clock) disable iff (reset)
    cplValid && tracking && !forward
    |=> count == (($past(count) > {1'b0, $past(cplSize)}) ?
                  $past(count) - {1'b0, $past(cplSize)} : '0))
    else $error("counter did not subtract");
endmodule : dsl_limiter
`default_nettype wire

// file: dsl_cpl_model.sv
// Secondary-side completer model: returns granted split reads when asked
`default_nettype none
module dsl_cpl_model (
  // Clock and reset
  input  wire logic              clock,
  input  wire logic              reset,
  // Observed request side
  input  wire logic              reqValid,
  input  wire dsl_pkg::dsl_adq_t reqSize,
  input  wire logic              reqGrant,
  input  wire logic              drain,
  // Completion side
  output logic                   cplValid,
  output dsl_pkg::dsl_adq_t      cplSize
);
  timeunit 1ns;
  timeprecision 1ns;
  import dsl_pkg::*;
  dsl_adq_t sz1;
  dsl_adq_t owed[$];
  initial cplValid = 0;
  initial cplSize = '0;
  // Grant lags the request by one edge, so the size waits one edge
  always @(posedge clock) begin
    sz1 <= reqValid ? reqSize : '0;
    if (reset) owed.delete();
    else if (reqGrant) owed.push_back(sz1);
    if (!reset && drain && owed.size() > 0) begin
      cplValid <= 1;
      cplSize  <= owed.pop_front();
    end else begin
      cplValid <= 0;
      cplSize  <= ~cplSize;
    end
  end
endmodule : dsl_cpl_model
`default_nettype wire

// file: dsl_limiter_tb.sv
// Self-checking bench for the split commitment limiter
`default_nettype none
module dsl_limiter_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import dsl_pkg::*;
  logic        clock = 0, reset = 1, regWrite = 0, regRead = 0, drain = 0;
  logic        eepromLoad = 0, reqValid = 0, reqGrant, reqHeld, cplValid, trackExact;
  logic [7:0]  regAddr = '0;
  logic [31:0] regWrData = '0, regRdData;
  dsl_adq_t    eepromLimit = '0, reqSize = '0, cplSize;
  int          mismatches = 0, checks_done = 0;
  always #25 clock = ~clock;
  dsl_limiter dut (.clock(clock), .reset(reset), .regAddr(regAddr), .regWrData(regWrData),
    .regWrite(regWrite), .regRead(regRead), .regRdData(regRdData), .eepromLoad(eepromLoad),
    .eepromLimit(eepromLimit), .reqValid(reqValid), .reqSize(reqSize), .reqGrant(reqGrant),
    .reqHeld(reqHeld), .cplValid(cplValid), .cplSize(cplSize), .trackExact(trackExact));
  dsl_cpl_model far (.clock(clock), .reset(reset), .reqValid(reqValid), .reqSize(reqSize),
    .reqGrant(reqGrant), .drain(drain), .cplValid(cplValid), .cplSize(cplSize));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      mismatches++;
      $display("Error at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    regAddr <= a;
    regWrData <= d;
    regWrite <= 1;
    @(posedge clock);
    regWrite <= 0;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    @(posedge clock);
    regAddr <= a;
    regRead <= 1;
    @(posedge clock);
    regRead <= 0;
    @(negedge clock);
    chk(regRdData, exp);
  endtask : rd
  // Grant or hold shows one cycle after the request edge
  task automatic req(input dsl_adq_t s, input logic g);
    @(posedge clock);
    reqValid <= 1;
    reqSize <= s;
    @(posedge clock);
    reqValid <= 0;
    @(negedge clock);
    chk({30'h0, reqGrant, reqHeld}, g ? 32'h0000_0002 : 32'h0000_0001);
  endtask : req
  task automatic flush;
    @(posedge clock);
    drain <= 1;
    repeat (6) @(posedge clock);
    drain <= 0;
  endtask : flush
  task automatic complete_run;
    if (mismatches == 0 && checks_done > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : complete_run
  initial begin
    repeat (5000) @(posedge clock);
    mismatches++;
    complete_run();
  end
  initial begin
    repeat (6) @(posedge clock);
    reset <= 0;
    rd(8'h00, 32'h0010_0010);
    chk({31'h0000_0000, trackExact}, 32'h0000_0001);
    wr(8'h00, 32'h0018_abcd);
    rd(8'h00, 32'h0018_0010);
    rd(8'h0c, 32'h0000_0000);
    req(16'h0010, 1);
    req(16'h0008, 1);
    req(16'h0001, 0);
    rd(8'h04, 32'h0000_0018);
    wr(8'h00, 32'h0019_0000);
    req(16'h0001, 1);
    flush();
    rd(8'h04, 32'h0000_0000);
    wr(8'h00, 32'hffff_0000);
    req(16'h1000, 1);
    chk({31'h0000_0000, trackExact}, 32'h0000_0000);
    rd(8'h04, 32'h0000_0000);
    rd(8'h08, 32'h0000_0001);
    wr(8'h00, 32'h0020_0000);
    // Request in the cycle the limit leaves the unlimited value
    reqValid <= 1;
    reqSize <= 16'h0004;
    @(posedge clock);
    reqValid <= 0;
    @(negedge clock);
    chk({30'h0, reqGrant, reqHeld}, 32'h0000_0002);
    chk({31'h0000_0000, trackExact}, 32'h0000_0000);
    rd(8'h04, 32'h0000_0004);
    flush();
    rd(8'h08, 32'h0000_0002);
    chk({31'h0000_0000, trackExact}, 32'h0000_0001);
    req(16'h0020, 1);
    @(posedge clock);
    eepromLoad <= 1;
    eepromLimit <= 16'h0030;
    @(posedge clock);
    eepromLoad <= 0;
    rd(8'h00, 32'h0030_0010);
    complete_run();
  end
endmodule : dsl_limiter_tb
`default_nettype wire
